// *** msv_map.vh ***
// constants for the memory-select and volume switch block
`ifndef MSV_MAP_VH
`define MSV_MAP_VH
`define MSV_MEM_A      2'h0
`define MSV_MEM_B      2'h1
`define MSV_MEM_C      2'h2
`define MSV_MEM_D      2'h3
`define MSV_POL_PULLDN 1'b0
`define MSV_POL_PULLUP 1'b1
`define MSV_TYPE_MOM   1'b0
`define MSV_TYPE_STAT  1'b1
`define MSV_VOL_RST    4'h8
`define MSV_DEB_RST    16'h0000
`endif

// *** msv_switch_ctl.v ***
// memory-select switch and volume-control interpretation logic
`timescale 1ns/1ps
`include "msv_map.vh"
module msv_switch_ctl #(
   parameter VOL_W    = 4,
   parameter DEB_W    = 16,
   parameter TRIM_N   = 4,
   parameter TRIM_PAR = 19,
   parameter TRIM_VW  = 4
) (
   // clock and reset
   input  wire                 mclk_i,
   input  wire                 sys_rst_i,
   // switch pins
   input  wire                 select_input_first_i,
   input  wire                 select_input_second_i,
   input  wire                 volume_up_input_i,
   input  wire                 volume_down_input_i,
   // configuration
   input  wire                 switch_type_setting_i,
   input  wire                 last_mem_dedicate_i,
   input  wire                 first_input_polarity_i,
   input  wire                 second_input_polarity_i,
   input  wire                 vol_pin_polarity_i,
   input  wire [3:0]           mem_valid_i,
   input  wire                 telecoil_en_i,
   input  wire [DEB_W-1:0]     debounce_cycles_i,
   input  wire                 vol_digital_en_i,
   input  wire                 vol_analog_en_i,
   input  wire                 vol_external_i,
   input  wire [VOL_W-1:0]     vol_fixed_i,
   input  wire                 vol_log_taper_i,
   input  wire [VOL_W-1:0]     vol_analog_pos_i,
   // trimmer configuration: two-bit trimmer number per parameter
   input  wire [TRIM_PAR*2-1:0] trim_assign_i,
   input  wire [TRIM_N*TRIM_VW-1:0] trim_pos_i,
   // outputs
   output reg  [1:0]           mem_sel_o,
   output reg                  mem_change_o,
   output reg  [VOL_W-1:0]     volume_o,
   output reg                  vol_up_evt_o,
   output reg                  vol_down_evt_o,
   output reg  [TRIM_PAR*TRIM_VW-1:0] trim_par_o
);

   // closed-state from pin level and polarity
   function is_closed;
      input lvl;
      input pol;
      begin
         is_closed = (pol == `MSV_POL_PULLUP) ? ~lvl : lvl;
      end
   endfunction

   // memory A counts as valid whatever its bit says
   function mem_ok;
      input [1:0] idx;
      input [3:0] vld;
      begin
         mem_ok = (idx == `MSV_MEM_A) | vld[idx];
      end
   endfunction

   // open-time count holds at its top so a long wait cannot wrap
   function [DEB_W-1:0] deb_step;
      input [DEB_W-1:0] cnt;
      begin
         if (cnt == {DEB_W{1'b1}})
            deb_step = cnt;
         else
            deb_step = cnt + {{(DEB_W-1){1'b0}}, 1'b1};
      end
   endfunction

   // trimmer numbers beyond the fitted ones read trimmer 0, never X
   function [TRIM_VW-1:0] trim_pick;
      input [TRIM_N*TRIM_VW-1:0] pos;
      input [1:0]                idx;
      begin
         if (idx >= TRIM_N)
            trim_pick = pos[TRIM_VW-1:0];
         else
            trim_pick = pos[idx*TRIM_VW +: TRIM_VW];
      end
   endfunction

   // next valid memory above cur, wrapping to A; skip_d excludes D
   function [1:0] next_mem;
      input [1:0] cur;
      input [3:0] vld;
      input       skip_d;
      reg   [3:0] v;
      begin
         v = {vld[3] & ~skip_d, vld[2:1], 1'b1};
         if (cur == 2'h0 && v[1])
            next_mem = 2'h1;
         else if (cur <= 2'h1 && v[2])
            next_mem = 2'h2;
         else if (cur <= 2'h2 && v[3])
            next_mem = 2'h3;
         else
            next_mem = `MSV_MEM_A;
      end
   endfunction

   // synchronised, polarity-corrected switch states
   reg              s1_ff;
   reg              s2_ff;
   reg              vu_ff;
   reg              vd_ff;
   reg              s1_prv_ff;
   reg              vu_prv_ff;
   reg              vd_prv_ff;
   reg              started_ff;
   reg  [1:0]       saved_ff;
   reg              in_d_ff;
   reg  [DEB_W-1:0] deb_cnt_ff;
   reg  [1:0]       nxt_mem;
   reg  [1:0]       nxt_saved;
   reg              nxt_in_d;
   reg  [DEB_W-1:0] nxt_deb;
   reg  [1:0]       stat_sel;
   reg              s2_open_ok;
   wire             press1;
   wire             vol_up_press;
   wire             vol_dn_press;
   wire             dig_en;
   wire             ana_en;
   wire             up_step;
   wire             dn_step;
   wire [1:0]       sw_mode;
   integer          k;

   // mode codes: {switch type, dedicate}
   localparam MODE_1 = 2'h0;
   localparam MODE_2 = 2'h1;
   localparam MODE_3 = 2'h2;
   localparam MODE_4 = 2'h3;

   // inputs are synchronous; one register stage gives edge detection
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         s1_ff     <= 1'b0;
         s2_ff     <= 1'b0;
         vu_ff     <= 1'b0;
         vd_ff     <= 1'b0;
         s1_prv_ff <= 1'b0;
         vu_prv_ff <= 1'b0;
         vd_prv_ff <= 1'b0;
      end else begin
         s1_ff     <= is_closed(select_input_first_i, first_input_polarity_i);
         s2_ff     <= is_closed(select_input_second_i, second_input_polarity_i);
         vu_ff     <= is_closed(volume_up_input_i, vol_pin_polarity_i);
         vd_ff     <= is_closed(volume_down_input_i, vol_pin_polarity_i);
         s1_prv_ff <= s1_ff;
         vu_prv_ff <= vu_ff;
         vd_prv_ff <= vd_ff;
      end
   end

   assign press1       = s1_ff & ~s1_prv_ff;
   assign vol_up_press = vu_ff & ~vu_prv_ff;
   assign vol_dn_press = vd_ff & ~vd_prv_ff;

   // digital wins if both are requested, so both never act
   assign dig_en = vol_digital_en_i & vol_external_i;
   assign ana_en = vol_analog_en_i & ~vol_digital_en_i & vol_external_i;

   // both buttons at once is refused rather than guessed
   assign up_step = dig_en & vol_up_press & ~vol_dn_press;
   assign dn_step = dig_en & vol_dn_press & ~vol_up_press;

   assign sw_mode = {switch_type_setting_i, last_mem_dedicate_i};

   // static decode; D-only ignores input one when two closed
   always @* begin
      if (last_mem_dedicate_i) begin
         if (s2_ff)
            stat_sel = `MSV_MEM_D;
         else
            stat_sel = s1_ff ? `MSV_MEM_B : `MSV_MEM_A;
      end else begin
         stat_sel = {s2_ff, s1_ff};
      end
      // invalid selection falls back to A
      if (!mem_ok(stat_sel, mem_valid_i))
         stat_sel = `MSV_MEM_A;
   end

   // telecoil leaves D only after a full open period
   always @* begin
      s2_open_ok = 1'b1;
      if (telecoil_en_i && in_d_ff && deb_cnt_ff < debounce_cycles_i)
         s2_open_ok = 1'b0;
   end

   // memory selection per mode
   always @* begin
      nxt_mem   = mem_sel_o;
      nxt_saved = saved_ff;
      nxt_in_d  = in_d_ff;
      nxt_deb   = `MSV_DEB_RST;
      case (sw_mode)
         MODE_3, MODE_4: begin
            // continuous follow, start at switch state
            nxt_in_d = s2_ff & last_mem_dedicate_i &
                       mem_ok(`MSV_MEM_D, mem_valid_i);
            if (in_d_ff && !s2_ff) begin
               nxt_deb = deb_step(deb_cnt_ff);
               if (!s2_open_ok)
                  nxt_in_d = 1'b1;
            end
            if (nxt_in_d)
               nxt_mem = `MSV_MEM_D;
            else
               nxt_mem = stat_sel;
         end
         MODE_2: begin
            if (s2_ff) begin
               // force D, ignore input one, remember prior
               if (!in_d_ff)
                  nxt_saved = started_ff ? mem_sel_o : `MSV_MEM_A;
               nxt_in_d = 1'b1;
               nxt_mem  = `MSV_MEM_D;
            end else if (in_d_ff) begin
               nxt_deb = deb_step(deb_cnt_ff);
               if (s2_open_ok) begin
                  nxt_in_d = 1'b0;
                  nxt_mem  = saved_ff;
               end
            end else if (!started_ff) begin
               nxt_mem = `MSV_MEM_A;
            end else if (press1) begin
               nxt_mem = next_mem(mem_sel_o, mem_valid_i, 1'b1);
            end
         end
         MODE_1: begin
            nxt_in_d = 1'b0;
            if (!started_ff)
               nxt_mem = `MSV_MEM_A;
            else if (press1)
               nxt_mem = next_mem(mem_sel_o, mem_valid_i, 1'b0);
         end
         default: begin
            nxt_in_d = 1'b0;
            nxt_mem  = `MSV_MEM_A;
         end
      endcase
   end

   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         mem_sel_o    <= `MSV_MEM_A;
         mem_change_o <= 1'b0;
         saved_ff     <= `MSV_MEM_A;
         in_d_ff      <= 1'b0;
         deb_cnt_ff   <= `MSV_DEB_RST;
         started_ff   <= 1'b0;
      end else begin
         started_ff   <= 1'b1;
         mem_sel_o    <= nxt_mem;
         saved_ff     <= nxt_saved;
         in_d_ff      <= nxt_in_d;
         deb_cnt_ff   <= nxt_deb;
         // one-cycle pulse with new index on output
         mem_change_o <= (nxt_mem != mem_sel_o);
      end
   end

   // log taper approximated by squaring the position
   wire [2*VOL_W-1:0] sq_pos = vol_analog_pos_i * vol_analog_pos_i;
   wire [VOL_W-1:0]   ana_vol = vol_log_taper_i ?
                                sq_pos[2*VOL_W-1:VOL_W] : vol_analog_pos_i;

   // volume source: fixed, analog or digital steps
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         volume_o       <= `MSV_VOL_RST;
         vol_up_evt_o   <= 1'b0;
         vol_down_evt_o <= 1'b0;
      end else begin
         vol_up_evt_o   <= up_step;
         vol_down_evt_o <= dn_step;
         if (!vol_external_i)
            volume_o <= vol_fixed_i;
         else if (ana_en)
            volume_o <= ana_vol;
         else if (dig_en) begin
            // saturating steps
            if (up_step && volume_o != {VOL_W{1'b1}})
               volume_o <= volume_o + {{(VOL_W-1){1'b0}}, 1'b1};
            else if (dn_step && volume_o != {VOL_W{1'b0}})
               volume_o <= volume_o - {{(VOL_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // each parameter copies its assigned trimmer, one trimmer many params
   always @(posedge mclk_i) begin
      if (sys_rst_i) begin
         trim_par_o <= {(TRIM_PAR*TRIM_VW){1'b0}};
      end else begin
         for (k = 0; k < TRIM_PAR; k = k + 1)
            trim_par_o[k*TRIM_VW +: TRIM_VW] <=
               trim_pick(trim_pos_i, trim_assign_i[k*2 +: 2]);
      end
   end

endmodule // msv_switch_ctl

// *** msv_switch_model.sv ***
// user switch model: commanded closures turned into pin levels
`timescale 1ns/1ps
module msv_switch_model (
   // closures and wiring
   input  wire [3:0] closed_i,
   input  wire [2:0] pol_i,
   // pin levels
   output wire [3:0] pin_o
);
   // an open switch leaves its pin at the pull resistor level
   assign pin_o = closed_i ^ {pol_i[2], pol_i[2], pol_i[1], pol_i[0]};
endmodule // msv_switch_model

// *** msv_switch_ctl_chk.sv ***
// concurrent checks on the memory-select switch logic
`timescale 1ns/1ps
module msv_switch_ctl_chk (
   // clock and reset
   input wire       mclk_i,
   input wire       sys_rst_i,
   // pins and configuration
   input wire       select_input_first_i,
   input wire       select_input_second_i,
   input wire       switch_type_setting_i,
   input wire       last_mem_dedicate_i,
   input wire       first_input_polarity_i,
   input wire       second_input_polarity_i,
   input wire [3:0] mem_valid_i,
   // outputs
   input wire [1:0] mem_sel_o,
   input wire       mem_change_o
);
   default clocking dc @(posedge mclk_i);
   endclocking
   default disable iff (sys_rst_i);
   // closed states after polarity, as the user sees them
   wire       c1 = select_input_first_i ^ first_input_polarity_i;
   wire       c2 = select_input_second_i ^ second_input_polarity_i;
   wire       m1 = !switch_type_setting_i && !last_mem_dedicate_i;
   wire       m2 = !switch_type_setting_i && last_mem_dedicate_i;
   wire       m3 = switch_type_setting_i && !last_mem_dedicate_i;
   wire       m4 = switch_type_setting_i && last_mem_dedicate_i;
   wire [1:0] sel = {c2, c1};
   property p_chg; mem_change_o |-> mem_sel_o != $past(mem_sel_o); endproperty
   property p_sel; mem_sel_o != $past(mem_sel_o) |-> mem_change_o; endproperty
   property p_m1; m1 && mem_change_o |=> !mem_change_o; endproperty
   property p_m2d; (m2 && c2)[*4] |-> mem_sel_o == 2'h3; endproperty
   property p_m2h; (m2 && c2)[*5] |-> !mem_change_o; endproperty
   property p_m3b;
      (m3 && mem_valid_i == 4'hF && $stable(sel))[*4] |-> mem_sel_o == sel;
   endproperty
   property p_m3i;
      (m3 && !mem_valid_i[sel] && $stable(sel))[*4] |-> mem_sel_o == 2'h0;
   endproperty
   property p_m4d; (m4 && c2)[*4] |-> mem_sel_o == 2'h3; endproperty
   a_chg: assert property (p_chg) else $error("pulse w/o change");
   a_sel: assert property (p_sel) else $error("change w/o pulse");
   a_m1: assert property (p_m1) else $error("pulse too long");
   a_m2d: assert property (p_m2d) else $error("no jump to D");
   a_m2h: assert property (p_m2h) else $error("moved while in D");
   a_m3b: assert property (p_m3b) else $error("binary select");
   a_m3i: assert property (p_m3i) else $error("no fallback");
   a_m4d: assert property (p_m4d) else $error("mode 4 not D");
   cover property (m1 && mem_change_o && mem_sel_o == 2'h0);
   cover property (m2 && mem_change_o && mem_sel_o == 2'h3);
   cover property (m3 && mem_change_o);
endmodule // msv_switch_ctl_chk
bind msv_switch_ctl msv_switch_ctl_chk u_chk (
   .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .mem_valid_i(mem_valid_i),
   .select_input_first_i(select_input_first_i),
   .select_input_second_i(select_input_second_i),
   .switch_type_setting_i(switch_type_setting_i),
   .last_mem_dedicate_i(last_mem_dedicate_i),
   .first_input_polarity_i(first_input_polarity_i),
   .second_input_polarity_i(second_input_polarity_i),
   .mem_sel_o(mem_sel_o), .mem_change_o(mem_change_o));

// *** msv_switch_ctl_bench.sv ***
// self-checking bench for the memory-select and volume switch block
`timescale 1ns/1ps
module msv_switch_ctl_bench;
   reg         mclk = 1'b0, rst = 1'b1, styp = 1'b0, ded = 1'b0;
   reg         den = 1'b1, aen = 1'b0, ext = 1'b1, tap = 1'b0;
   reg  [3:0]  cl = 4'h0, vld = 4'hF, apos = 4'h0;
   reg  [2:0]  pol = 3'h0;
   wire [3:0]  pin, vol;
   wire [1:0]  msel;
   wire [75:0] trim;
   integer     n_fail = 0, checked = 0, cyc = 0, i;
   reg         tel = 1'b0;
   reg  [15:0] deb = 16'h0000;
   reg  [3:0]  n_up = 4'h0, n_dn = 4'h0;
   wire        up_evt, dn_evt;
   msv_switch_model u_msv_switch_model (.closed_i(cl), .pol_i(pol), .pin_o(pin));
   msv_switch_ctl u_msv_switch_ctl (
      .mclk_i(mclk), .sys_rst_i(rst),
      .select_input_first_i(pin[0]), .select_input_second_i(pin[1]),
      .volume_up_input_i(pin[2]), .volume_down_input_i(pin[3]),
      .switch_type_setting_i(styp), .last_mem_dedicate_i(ded),
      .first_input_polarity_i(pol[0]), .second_input_polarity_i(pol[1]),
      .vol_pin_polarity_i(pol[2]), .mem_valid_i(vld),
      .telecoil_en_i(tel), .debounce_cycles_i(deb),
      .vol_digital_en_i(den), .vol_analog_en_i(aen),
      .vol_external_i(ext), .vol_fixed_i(4'h5),
      .vol_log_taper_i(tap), .vol_analog_pos_i(apos),
      .trim_assign_i(38'h0), .trim_pos_i(16'h0007),
      .mem_sel_o(msel), .mem_change_o(), .volume_o(vol),
      .vol_up_evt_o(up_evt), .vol_down_evt_o(dn_evt), .trim_par_o(trim));
   initial forever #25 mclk = ~mclk;
   task test_done;
      begin
         $display("checked %0d n_fail %0d", checked, n_fail);
         if (n_fail == 0 && checked > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   // let the edge's own updates land before looking
   task chk_mem(input [1:0] e);
      begin
         #1 checked = checked + 1;
         if (msel !== e) begin
            n_fail = n_fail + 1;
            $display("Error %0t memory %h, expected %h", $time, msel, e);
         end
      end
   endtask
   task chk_val(input [3:0] got, input [3:0] e);
      begin
         #1 checked = checked + 1;
         if (got !== e) begin
            n_fail = n_fail + 1;
            $display("Error %0t value %h, expected %h", $time, got, e);
         end
      end
   endtask
   // a press needs open samples on both sides to count once
   task press(input integer k);
      begin
         @(posedge mclk) cl[k] <= 1'b1;
         repeat (3) @(posedge mclk);
         cl[k] <= 1'b0;
         repeat (4) @(posedge mclk);
      end
   endtask
   task setsw(input [1:0] s);
      begin
         @(posedge mclk) cl[1:0] <= s;
         repeat (6) @(posedge mclk);
      end
   endtask
   always @(posedge mclk) begin
      cyc = cyc + 1;
      if (cyc == 1500) begin
         n_fail = n_fail + 1;
         test_done;
      end
   end
   // one-cycle step pulses are tallied so a check can look later
   always @(posedge mclk) begin
      if (up_evt)
         n_up <= n_up + 4'h1;
      if (dn_evt)
         n_dn <= n_dn + 4'h1;
   end
   initial begin
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      chk_mem(2'h0);
      chk_val(vol, 4'h8);
      for (i = 1; i < 5; i = i + 1) begin
         press(0);
         chk_mem(2'(i));
      end
      @(posedge mclk) vld <= 4'h3;
      press(0);
      chk_mem(2'h1);
      press(0);
      chk_mem(2'h0);
      @(posedge mclk) ded <= 1'b1;
      vld <= 4'hF;
      for (i = 1; i < 5; i = i + 1) begin
         press(0);
         chk_mem(2'(i % 3));
      end
      setsw(2'b10);
      chk_mem(2'h3);
      press(0);
      chk_mem(2'h3);
      setsw(2'b00);
      chk_mem(2'h1);
      @(posedge mclk) tel <= 1'b1;
      deb <= 16'h000A;
      setsw(2'b10);
      chk_mem(2'h3);
      setsw(2'b00);
      chk_mem(2'h3);
      repeat (6) @(posedge mclk);
      chk_mem(2'h1);
      @(posedge mclk) styp <= 1'b1;
      tel <= 1'b0;
      ded <= 1'b0;
      pol <= 3'b011;
      for (i = 0; i < 4; i = i + 1) begin
         setsw(2'(i));
         chk_mem(2'(i));
      end
      @(posedge mclk) vld <= 4'hB;
      setsw(2'b10);
      chk_mem(2'h0);
      @(posedge mclk) ded <= 1'b1;
      setsw(2'b01);
      chk_mem(2'h1);
      setsw(2'b11);
      chk_mem(2'h3);
      press(2);
      chk_val(vol, 4'h9);
      chk_val(n_up, 4'h1);
      press(3);
      chk_val(vol, 4'h8);
      chk_val(n_dn, 4'h1);
      @(posedge mclk) den <= 1'b0;
      aen <= 1'b1;
      apos <= 4'hA;
      repeat (4) @(posedge mclk);
      chk_val(vol, 4'hA);
      @(posedge mclk) tap <= 1'b1;
      apos <= 4'hC;
      repeat (4) @(posedge mclk);
      chk_val(vol, 4'h9);
      @(posedge mclk) ext <= 1'b0;
      repeat (4) @(posedge mclk);
      chk_val(vol, 4'h5);
      chk_val(trim[75:72], 4'h7);
      test_done;
   end
endmodule // msv_switch_ctl_bench
